// ---- verilog/poll_pkg.sv ----
// Package: constants for the flash status polling controller
package poll_pkg;

   // ==================================================================
   // APB register map (byte addresses)
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] ADDR_OFS     = 8'h04;
   localparam logic [7:0] STATUS_OFS   = 8'h08;
   localparam logic [7:0] LAST_OFS     = 8'h0C;
   localparam logic [7:0] RDDATA_OFS   = 8'h10;

   // CTRL fields (write strobes, self clearing)
   localparam int CTRL_START    = 0;
   localparam int CTRL_ABORT_BUF = 1;
   localparam int CTRL_RESET_CMD = 2;

   // ==================================================================
   // Status word bit positions
   localparam int POLLING_DATA_BIT  = 7;
   localparam int TOGGLE_BIT_ONE    = 6;
   localparam int TIMEOUT_FLAG_BIT  = 5;
   localparam int ERASE_TIMER_BIT   = 3;
   localparam int TOGGLE_BIT_TWO    = 2;
   localparam int BUFFER_ABORT_BIT  = 1;
   // Meaningful bits; 15..8, 4 and 0 are masked as don't care
   localparam logic [15:0] STATUS_MASK = 16'h00EE;

   // ==================================================================
   // Flash bus timing
   localparam int CLK_MHZ        = 100;
   localparam int READ_NS        = 100;
   localparam int READ_CYC       = (READ_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_NS       = 60;
   localparam int WRITE_CYC      = (WRITE_NS * CLK_MHZ + 999) / 1000;
   localparam int RECOVER_NS     = 2000;
   localparam int RECOVER_CYC    = (RECOVER_NS * CLK_MHZ + 999) / 1000;

   // Command sequence values
   localparam logic [15:0] CMD_RESET = 16'h00F0;
   localparam logic [15:0] CMD_UNLK1 = 16'h00AA;
   localparam logic [15:0] CMD_UNLK2 = 16'h0055;
   localparam logic [23:0] UNLK1_ADR = 24'h00_0555;
   localparam logic [23:0] UNLK2_ADR = 24'h00_02AA;

   // Result codes in STATUS
   typedef enum logic [2:0] {RES_NONE, RES_DONE, RES_FAIL, RES_ABORT} result_t;
   typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} bus_op_t;

endpackage : poll_pkg

// ---- verilog/flash_bus_if.sv ----
// Interface: request path between the poll sequencer and the flash pin driver
`timescale 1ns/10ps
interface flash_bus_if;
   import poll_pkg::*;
   bus_op_t       op;        // Requested cycle
   logic [23:0]   addr;      // Cycle address
   logic [15:0]   wdata;     // Write data
   logic          busy;      // Cycle in progress
   logic          done;      // One-cycle completion pulse
   logic [15:0]   rdata;     // Captured read data

   modport seq (output op, addr, wdata, input busy, done, rdata);
   modport drv (input op, addr, wdata, output busy, done, rdata);
endinterface : flash_bus_if

// ---- verilog/flash_pin_driver.sv ----
// Module: runs single asynchronous read and write cycles on the flash pins
`timescale 1ns/10ps
module flash_pin_driver
   import poll_pkg::*;
(
   input  wire logic          core_clk,   // System clock
   input  wire logic          resetn,     // Synchronous reset, active low
   flash_bus_if.drv           bus,        // Request side
   output logic [23:0]        fl_addr,    // Flash address
   output logic [15:0]        fl_dq_out,  // Data out
   output logic               fl_dq_oe,   // Data drive enable
   input  wire logic [15:0]   fl_dq_in,   // Data in
   output logic               fl_ce_n,    // Chip enable, low active
   output logic               fl_oe_n,    // Output enable, low active
   output logic               fl_we_n     // Write enable, low active
);
   import poll_pkg::*;

   // ==================================================================
   // Cycle timer
   logic [7:0]  count;
   logic        active;
   logic        is_wr;
   logic [15:0] dq_s1;
   logic [15:0] dq_s2;
   wire  [7:0]  cyc_len = is_wr ? 8'(WRITE_CYC) : 8'(READ_CYC + 2);
   wire         last    = active && (count == cyc_len);

   // Pin data passes two flops; cycle length covers that latency
   always_ff @(posedge core_clk)
   begin
      dq_s1 <= fl_dq_in;
      dq_s2 <= dq_s1;
   end

   // Start, hold and end one cycle; strobes come from flops
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         active    <= 1'b0;
         is_wr     <= 1'b0;
         count     <= '0;
         fl_addr   <= '0;
         fl_dq_out <= '0;
         fl_dq_oe  <= 1'b0;
         fl_ce_n   <= 1'b1;
         fl_oe_n   <= 1'b1;
         fl_we_n   <= 1'b1;
         bus.done  <= 1'b0;
         bus.rdata <= '0;
      end
      else
      begin
         bus.done <= last;
         if (!active && bus.op != BUS_IDLE)
         begin
            active    <= 1'b1;
            count     <= 8'h01;
            is_wr     <= (bus.op == BUS_WRITE);
            fl_addr   <= bus.addr;
            fl_dq_out <= bus.wdata;
            fl_dq_oe  <= (bus.op == BUS_WRITE);
            fl_ce_n   <= 1'b0;
            fl_oe_n   <= (bus.op == BUS_WRITE);
            fl_we_n   <= (bus.op != BUS_WRITE);
         end
         else if (last)
         begin
            active   <= 1'b0;
            fl_ce_n  <= 1'b1;
            fl_oe_n  <= 1'b1;
            fl_we_n  <= 1'b1;
            fl_dq_oe <= 1'b0;
            if (!is_wr)
               bus.rdata <= dq_s2;
         end
         else if (active)
            count <= count + 8'h01;
      end
   end

   assign bus.busy = active || bus.done;
endmodule : flash_pin_driver

// ---- verilog/flash_status_poller.sv ----
// Module: APB controlled host that polls flash embedded-algorithm status
// Notes on behaviour
// - Host starts polling with two back-to-back status reads, comparing toggle bit.
// - Toggle unchanged between reads means done; array data readable next cycle.
// - Toggling with timeout set: read once more against the last read; stopped is success.
// - Still toggling with timeout set is failure; host writes reset command.
// - Leaving polling mid-operation means restarting from the initial double read.
// - On timeout host sends reset; device may stay busy up to 2 us.
// - After buffer abort host issues the abort-reset sequence; device returns to read.
// - In program-suspend host must not trust reads inside the suspended line; this host does not detect suspend and takes a steady toggle bit as done.
// - Host polls at the programmed location or an erasing sector address.
`timescale 1ns/10ps
module flash_status_poller
   import poll_pkg::*;
(
   input  wire logic          core_clk,    // System clock, 100 MHz
   input  wire logic          resetn,      // Synchronous reset, active low
   input  wire logic          psel,        // APB select
   input  wire logic          penable,     // APB enable
   input  wire logic          pwrite,      // APB direction
   input  wire logic [7:0]    paddr,       // APB byte address
   input  wire logic [31:0]   pwdata,      // APB write data
   output logic [31:0]        prdata,      // APB read data
   output logic               pready,      // APB ready
   output logic               pslverr,     // APB error
   output logic [23:0]        fl_addr,     // Flash address
   output logic [15:0]        fl_dq_out,   // Flash data out
   output logic               fl_dq_oe,    // Flash data drive enable
   input  wire logic [15:0]   fl_dq_in,    // Flash data in
   output logic               fl_ce_n,     // Flash chip enable
   output logic               fl_oe_n,     // Flash output enable
   output logic               fl_we_n,     // Flash write enable
   input  wire logic          ready_busy_pin // Device ready/busy, low busy
);
   import poll_pkg::*;

   // ==================================================================
   // Sequencer states
   typedef enum logic [3:0] {
      S_IDLE, S_RD1, S_RD2, S_EVAL, S_RECHK, S_SEND, S_WAIT_RB, S_ARRAY
   } state_t;

   state_t       state;
   state_t       next_state;
   flash_bus_if  bus ();

   // ==================================================================
   // Registers
   logic [23:0]  poll_addr;     // Program location or erasing sector
   logic [15:0]  first_word;    // First of a read pair
   logic [15:0]  last_word;     // Latest status word, masked
   logic [15:0]  array_word;    // Data read after completion
   result_t      result;
   logic         running;
   logic [1:0]   cmd_idx;       // Step through a command sequence
   logic         cmd_abort;     // Abort-reset (3 writes) or plain reset (1)
   logic         recheck;       // Pair is the recheck after timeout
   logic [11:0]  wait_cnt;
   logic         rb_s1;
   logic         rb_s2;

   // Masked status; reserved bits never enter a decision
   wire [15:0] masked   = bus.rdata & STATUS_MASK;
   wire [15:0] first_m  = first_word & STATUS_MASK;
   wire        toggling = masked[TOGGLE_BIT_ONE] != first_m[TOGGLE_BIT_ONE];
   wire        timeout  = masked[TIMEOUT_FLAG_BIT];
   wire        aborted  = masked[BUFFER_ABORT_BIT];
   // A read pair that ended with the toggle bit still moving
   wire        pair_end = (state == S_RD2 || state == S_RECHK) && bus.done && toggling;

   // APB decode
   wire        apb_acc  = psel && penable;
   wire        apb_wr   = apb_acc && pwrite;
   wire        hit_ctrl = apb_wr && (paddr == CTRL_OFS);
   wire        hit_addr = apb_wr && (paddr == ADDR_OFS);
   wire        start    = hit_ctrl && pwdata[CTRL_START] && !running;
   wire        sw_reset = hit_ctrl && pwdata[CTRL_RESET_CMD] && !running;
   wire        sw_abrst = hit_ctrl && pwdata[CTRL_ABORT_BUF] && !running;
   wire        mapped   = (paddr == CTRL_OFS) || (paddr == ADDR_OFS) ||
                          (paddr == STATUS_OFS) || (paddr == LAST_OFS) ||
                          (paddr == RDDATA_OFS);

   // Command sequence table: reset or abort-reset
   function automatic logic [39:0] cmd_word(input logic abrt, input logic [1:0] idx);
      logic [39:0] w;
      w = {UNLK1_ADR, CMD_RESET};
      if (abrt)
         unique case (idx)
            2'd0: w = {UNLK1_ADR, CMD_UNLK1};
            2'd1: w = {UNLK2_ADR, CMD_UNLK2};
            default: w = {UNLK1_ADR, CMD_RESET};
         endcase
      return w;
   endfunction : cmd_word

   wire [39:0] cur_cmd  = cmd_word(cmd_abort, cmd_idx);
   wire        cmd_last = !cmd_abort || (cmd_idx == 2'd2);

   // ==================================================================
   // Flash pin driver
   flash_pin_driver u_drv (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .bus       (bus),
      .fl_addr   (fl_addr),
      .fl_dq_out (fl_dq_out),
      .fl_dq_oe  (fl_dq_oe),
      .fl_dq_in  (fl_dq_in),
      .fl_ce_n   (fl_ce_n),
      .fl_oe_n   (fl_oe_n),
      .fl_we_n   (fl_we_n)
   );

   // Requests to the driver; one request per idle driver
   always_comb
   begin
      bus.op    = BUS_IDLE;
      bus.addr  = poll_addr;
      bus.wdata = '0;
      if (!bus.busy)
         unique case (state)
            S_RD1, S_RD2, S_RECHK, S_ARRAY: bus.op = BUS_READ;
            S_SEND:
            begin
               bus.op    = BUS_WRITE;
               bus.addr  = cur_cmd[39:16];
               bus.wdata = cur_cmd[15:0];
            end
            default: bus.op = BUS_IDLE;
         endcase
   end

   // ==================================================================
   // Polling decision
   always_comb
   begin
      next_state = state;
      unique case (state)
         S_IDLE:
            if (start)
               next_state = S_RD1;
            else if (sw_reset || sw_abrst)
               next_state = S_SEND;
         S_RD1:
            if (bus.done)
               next_state = S_RD2;
         S_RD2, S_RECHK:
            if (bus.done)
            begin
               if (!toggling)
                  next_state = S_ARRAY;
               else if (aborted)
                  next_state = S_SEND;
               else if (timeout && state == S_RECHK)
                  next_state = S_SEND;
               else if (timeout)
                  next_state = S_RECHK;
               else
                  next_state = S_RD2;                         // Keep polling
            end
         S_SEND:
            if (bus.done && cmd_last)
               next_state = S_WAIT_RB;
         S_WAIT_RB:
            if (rb_s2 || wait_cnt == 12'(RECOVER_CYC))
               next_state = S_IDLE;
         S_ARRAY:
            if (bus.done)
               next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   // Ready/busy pin synchroniser
   always_ff @(posedge core_clk)
   begin
      rb_s1 <= ready_busy_pin;
      rb_s2 <= rb_s1;
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         state <= S_IDLE;
      else
         state <= next_state;
   end

   // Keep the newer read as the reference of the next pair
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         first_word <= '0;
         last_word  <= '0;
      end
      else if (bus.done && state inside {S_RD1, S_RD2, S_RECHK})
      begin
         first_word <= bus.rdata;
         last_word  <= masked;
      end
   end

   // Array word is taken only after toggling stopped; a suspended line is
   // not detected, so a steady toggle bit there also ends polling
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         array_word <= '0;
      else if (state == S_ARRAY && bus.done)
         array_word <= bus.rdata;
   end

   // Verdict of the last poll; a new start clears it
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         result <= RES_NONE;
      else if (start)
         result <= RES_NONE;
      else if (pair_end && aborted)
         result <= RES_ABORT;
      else if (pair_end && timeout && state == S_RECHK)
         result <= RES_FAIL;
      else if (state == S_ARRAY && bus.done)
         result <= RES_DONE;
   end

   // Command sequence choice and step; the abort-reset takes three writes
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         cmd_abort <= 1'b0;
         cmd_idx   <= '0;
      end
      else if (sw_reset || sw_abrst)
      begin
         cmd_abort <= sw_abrst;
         cmd_idx   <= '0;
      end
      else if (pair_end && aborted)
      begin
         cmd_abort <= 1'b1;
         cmd_idx   <= '0;
      end
      else if (pair_end && timeout && state == S_RECHK)
      begin
         cmd_abort <= 1'b0;
         cmd_idx   <= '0;
      end
      else if (state == S_SEND && bus.done && !cmd_last)
         cmd_idx <= cmd_idx + 2'd1;
   end

   // Recheck flag and recovery wait; the bound keeps a stuck pin from hanging us
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         recheck  <= 1'b0;
         wait_cnt <= '0;
      end
      else
      begin
         recheck  <= (next_state == S_RECHK);
         wait_cnt <= (state == S_WAIT_RB) ? wait_cnt + 12'd1 : 12'd0;
      end
   end

   assign running = (state != S_IDLE);

   // ==================================================================
   // APB slave: zero wait, error on unmapped address
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         poll_addr <= '0;
      else if (hit_addr)
         poll_addr <= pwdata[23:0];
   end

   always_comb
   begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         ADDR_OFS:   prdata = {8'h00, poll_addr};
         STATUS_OFS: prdata = {25'h000_0000, recheck, ~rb_s2, running, 1'b0, result};
         LAST_OFS:   prdata = {16'h0000, last_word};
         RDDATA_OFS: prdata = {16'h0000, array_word};
         default:    prdata = 32'h0000_0000;
      endcase
   end

   assign pready  = 1'b1;
   assign pslverr = apb_acc && !mapped;
endmodule : flash_status_poller

// ---- tb/poll_checker.sv ----
// Checker: APB and flash pin relations of the status poller
`timescale 1ns/10ps
module poll_checker
   import poll_pkg::*;
(
   input wire logic        core_clk,  // Clock
   input wire logic        resetn,    // Reset, active low
   input wire logic        psel,      // APB select
   input wire logic        penable,   // APB enable
   input wire logic [7:0]  paddr,     // APB address
   input wire logic        pready,    // APB ready
   input wire logic        pslverr,   // APB error
   input wire logic [23:0] fl_addr,   // Flash address
   input wire logic [15:0] fl_dq_out, // Flash data out
   input wire logic        fl_dq_oe,  // Data drive enable
   input wire logic        fl_ce_n,   // Chip enable
   input wire logic        fl_oe_n,   // Output enable
   input wire logic        fl_we_n    // Write enable
);
   wire logic mapped;
   // ==================================================================
   // Address decode kept apart so the error checks read plainly
   assign mapped = paddr inside {CTRL_OFS, ADDR_OFS, STATUS_OFS, LAST_OFS, RDDATA_OFS};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_apb_ready: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
      else $error("unmapped access without error");
   a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
      else $error("mapped access flagged as error");
   a_read_hold: assert property ($fell(fl_oe_n) |-> (!fl_oe_n && fl_we_n)[*8])
      else $error("read strobe shorter than eight cycles");
   a_ce_gap: assert property ($rose(fl_ce_n) |=> fl_ce_n)
      else $error("chip enable gap under two cycles");
   a_addr_steady: assert property (!fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr))
      else $error("address moved inside a cycle");
   a_write_drive: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n && fl_oe_n)
      else $error("write without data drive");
   a_write_data: assert property (!fl_we_n && !$past(fl_we_n) |-> $stable(fl_dq_out))
      else $error("write data moved inside a cycle");
   a_no_contend: assert property (!fl_oe_n |-> !fl_dq_oe)
      else $error("host drives bus during a read");
endmodule : poll_checker

// ---- tb/flash_model.sv ----
// Behavioural flash device answering status polls and commands
`timescale 1ns/10ps
module flash_model
(
   input  wire logic [15:0] dq_in,    // Resolved data bus
   input  wire logic        fl_dq_oe, // Host drives the bus
   input  wire logic        fl_oe_n,  // Output enable
   input  wire logic        fl_we_n,  // Write enable
   input  wire logic        start_op, // Bench launches an operation
   input  wire logic [2:0]  kind,     // 0 prog, 1 erase, 2 timeout, 3 abort, 4 suspend
   input  wire logic [7:0]  nreads,   // Busy reads before the algorithm ends
   input  wire logic [15:0] arr,      // Array word
   output logic [15:0]      dq_drv,   // Device side of the bus
   output logic             rb,       // Ready/busy pin
   output int               n_f0,     // Reset writes seen
   output int               n_aa      // First unlock (AA) writes seen
);
   logic busy;
   logic tog;
   logic [7:0] left;
   logic [15:0] last;
   logic [15:0] stat;
   logic [15:0] wd;
   // Status word, the same at every address while busy
   assign stat = {8'h00, kind == 1 ? 1'b0 : (kind == 4 ? 1'b1 : ~arr[7]), kind != 4 && tog,
                  kind == 2, 1'b0, kind == 1, (kind == 1 || kind == 4) && tog, kind == 3,
                  1'b0};
   // Released bus shows the inverse so a stale value never passes
   assign dq_drv = fl_oe_n ? ~last : last;
   initial
   begin
      busy = 0;
      tog = 0;
      rb = 1;
      n_f0 = 0;
      n_aa = 0;
      last = 16'h0000;
      wd = 16'h0000;
   end
   always @(posedge start_op)
   begin
      busy = 1;
      tog = 0;
      left = nreads;
   end
   // Each busy read flips the toggle bit; array data once done
   always @(negedge fl_oe_n)
   begin
      last = busy ? stat : arr;
      if (busy)
      begin
         tog = ~tog;
         left = left - 8'h01;
         if (left == 8'h00) busy = 0;
      end
   end
   always @(fl_we_n or dq_in) if (!fl_we_n && fl_dq_oe) wd = dq_in;
   // Reset write clears error status and returns to standby
   always @(posedge fl_we_n)
   begin
      if (wd[7:0] == 8'hAA) n_aa = n_aa + 1;
      if (wd[7:0] == 8'hF0)
      begin
         n_f0 = n_f0 + 1;
         busy = 0;
      end
   end
   // Busy pin drops at once and rises 1 us after the algorithm ends, inside the allowed 2 us
   // Erase-suspend keeps the pin high
   always @(busy) if (busy && kind != 3'd4) rb = 0; else rb <= #1000 1'b1;
endmodule : flash_model

// ---- tb/tb.sv ----
// Top testbench: APB driven polling scenarios against the flash model
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
   import poll_pkg::*;
   logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, fl_dq_oe;
   logic fl_ce_n, fl_oe_n, fl_we_n, ready_busy_pin, start_op;
   logic [7:0]  paddr, nreads;
   logic [31:0] pwdata, prdata;
   logic [23:0] fl_addr;
   logic [15:0] fl_dq_out, fl_dq_in, dq_drv;
   logic [2:0]  kind;
   int          n_f0, n_aa, fail_count, tests_run;
   localparam logic [15:0] ARR = 16'h5A4C; // Bit 6 set so the recheck sees it steady
   // Bus level from the host's drive enable; the model drives it otherwise
   assign fl_dq_in = fl_dq_oe ? fl_dq_out : dq_drv;
   flash_status_poller DUT (.core_clk(core_clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
      .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
      .fl_we_n(fl_we_n), .ready_busy_pin(ready_busy_pin));
   flash_model MDL (.dq_in(fl_dq_in), .fl_dq_oe(fl_dq_oe), .fl_oe_n(fl_oe_n),
      .fl_we_n(fl_we_n), .start_op(start_op), .kind(kind), .nreads(nreads), .arr(ARR),
      .dq_drv(dq_drv), .rb(ready_busy_pin), .n_f0(n_f0), .n_aa(n_aa));
   initial
   begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   // One APB transfer; an idle edge first keeps each signal to one write per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Launch a device operation, start polling, wait until the poller is idle
   task automatic run_op(input logic [2:0] k, input logic [7:0] n, output logic [31:0] st);
      logic e;
      kind <= k;
      nreads <= n;
      start_op <= 1'b1;
      apb(1'b1, ADDR_OFS, 32'h0000_0100, st, e);
      apb(1'b1, CTRL_OFS, 32'h0000_0001, st, e);
      start_op <= 1'b0;
      wait_idle(st);
   endtask : run_op
   // Poll STATUS until the poller is idle; a poller that never ends is a mismatch
   task automatic wait_idle(output logic [31:0] st);
      logic e;
      int i;
      i = 0;
      do
      begin
         apb(1'b0, STATUS_OFS, 32'h0000_0000, st, e);
         i++;
      end
      while (st[4] !== 1'b0 && i < 1000);
      if (st[4] !== 1'b0)
         fail_count++;
   endtask : wait_idle
   // Direct reset and abort-reset commands from an idle poller
   task automatic s_cmd();
      logic [31:0] r;
      logic e;
      int f0;
      int aa;
      f0 = n_f0;
      aa = n_aa;
      apb(1'b1, CTRL_OFS, 32'h0000_0004, r, e);
      wait_idle(r);
      `CHK("reset cmd writes", f0 + 1, n_f0)
      `CHK("reset cmd unlocks", aa, n_aa)
      apb(1'b1, CTRL_OFS, 32'h0000_0002, r, e);
      wait_idle(r);
      `CHK("abort cmd unlocks", aa + 1, n_aa)
      `CHK("abort cmd resets", f0 + 2, n_f0)
   endtask : s_cmd
   // Erase-suspended sector: steady bit 6 ends the poll, bit 7 high, pin ready
   task automatic s_suspend();
      logic [31:0] r;
      logic e;
      run_op(3'd4, 8'd3, r);
      `CHK("suspend result", RES_DONE, r[2:0])
      `CHK("suspend ready pin", 1'b0, r[5])
      apb(1'b0, LAST_OFS, 32'h0000_0000, r, e);
      `CHK("suspend status", 32'h0000_0084, r)
   endtask : s_suspend
   task automatic s_prog();
      logic [31:0] r;
      logic e;
      run_op(3'd0, 8'd5, r);
      `CHK("prog result", RES_DONE, r[2:0])
      apb(1'b0, RDDATA_OFS, 32'h0000_0000, r, e);
      `CHK("array word", {16'h0000, ARR}, r)
      apb(1'b0, LAST_OFS, 32'h0000_0000, r, e);
      `CHK("masked bits", 32'h0000_0000, r & ~{16'h0000, STATUS_MASK})
   endtask : s_prog
   task automatic s_erase();
      logic [31:0] r;
      int f0;
      f0 = n_f0;
      run_op(3'd1, 8'd6, r);
      `CHK("erase result", RES_DONE, r[2:0])
      `CHK("erase resets", f0, n_f0)
   endtask : s_erase
   task automatic s_tmo_ok();
      logic [31:0] r;
      int f0;
      f0 = n_f0;
      run_op(3'd2, 8'd2, r);
      `CHK("recheck result", RES_DONE, r[2:0])
      `CHK("recheck resets", f0, n_f0)
   endtask : s_tmo_ok
   task automatic s_tmo_fail();
      logic [31:0] r;
      int f0;
      f0 = n_f0;
      run_op(3'd2, 8'd200, r);
      `CHK("timeout result", RES_FAIL, r[2:0])
      `CHK("timeout resets", f0 + 1, n_f0)
      `CHK("ready after reset", 1'b1, ready_busy_pin)
   endtask : s_tmo_fail
   task automatic s_abort();
      logic [31:0] r;
      int f0;
      int aa;
      f0 = n_f0;
      aa = n_aa;
      run_op(3'd3, 8'd200, r);
      `CHK("abort result", RES_ABORT, r[2:0])
      `CHK("abort unlocks", aa + 1, n_aa)
      `CHK("abort resets", f0 + 1, n_f0)
   endtask : s_abort
   task automatic s_unmapped();
      logic [31:0] r;
      logic e;
      apb(1'b0, 8'h20, 32'h0000_0000, r, e);
      `CHK("unmapped read err", 1'b1, e)
      apb(1'b1, 8'h14, 32'h0000_0001, r, e);
      `CHK("unmapped write err", 1'b1, e)
      apb(1'b0, ADDR_OFS, 32'h0000_0000, r, e);
      `CHK("poll address", 32'h0000_0100, r)
      `CHK("mapped err", 1'b0, e)
   endtask : s_unmapped
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   // Watchdog: all scenarios need well under 50k cycles
   initial
   begin
      #500_000;
      fail_count++;
      stop_test();
   end
   initial
   begin
      {resetn, psel, penable, pwrite, start_op} = 5'b0_0000;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      kind = 3'd0;
      nreads = 8'd1;
      fail_count = 0;
      tests_run = 0;
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      s_prog();
      s_erase();
      s_tmo_ok();
      s_tmo_fail();
      s_abort();
      s_unmapped();
      s_cmd();
      s_suspend();
      s_prog();
      stop_test();
   end
endmodule : tb
bind flash_status_poller poll_checker CHK (.core_clk(core_clk), .resetn(resetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
   .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
